// >>> core/pcrc_pkg.sv
// constants and types shared by the programmable crc unit
// Notes on behaviour
// R1 - each data write folds into held crc; data read returns previous result; a third back-to-back data write replaces the unstarted buffered one
// R2 - crc runs over whole written width, byte by byte for narrow writes
// R3 - data register takes word, low half-word and low byte; others word only
// R4 - one write takes four cycles for word, two for half-word, one for byte
// R5 - an input buffer takes a second write at once, without wait states
// R6 - input reversal field 6:5 reorders bits by byte, half-word or word
// R7 - output reversal bit 7 fully reverses bit order of data reads
// R8 - size field 4:3 selects 32, 16, 8 or 7 bit polynomial
// R9 - polynomial register is software written and always used for calculation
// R10 - software programs odd polynomials only
// R11 - narrow crc sits in low bits; narrow writes taken from low bits unless input reversal grain is wider than the write
// R12 - writing one to bit 0 reloads data from start value, then self clears
// R13 - any start value write also loads the data register
// R14 - scratch register holds written value, untouched by the reset bit
// R15 - software changes polynomial only after reset or data read
// R16 - after reset polynomial is 04C11DB7, data and start value all ones
// R17 - data read stalls until calculation done; output reversal is view only
package pcrc_pkg;
  localparam logic [4:0]  PCRC_OFS_DATA      = 5'h00;
  localparam logic [4:0]  PCRC_OFS_SCRATCH   = 5'h04;
  localparam logic [4:0]  PCRC_OFS_CONTROL   = 5'h08;
  localparam logic [4:0]  PCRC_OFS_START     = 5'h10;
  localparam logic [4:0]  PCRC_OFS_COEFF     = 5'h14;
  localparam int          PCRC_BIT_RESET     = 0;
  localparam int          PCRC_POS_SIZE      = 3;
  localparam int          PCRC_POS_REVIN     = 5;
  localparam int          PCRC_BIT_REVOUT    = 7;
  localparam logic [31:0] PCRC_RST_DATA      = 32'hFFFFFFFF;
  localparam logic [31:0] PCRC_RST_SCRATCH   = 32'h00000000;
  localparam logic [31:0] PCRC_RST_START     = 32'hFFFFFFFF;
  localparam logic [31:0] PCRC_RST_COEFF     = 32'h04C11DB7;
  localparam logic [7:0]  PCRC_RST_CONTROL   = 8'h00;
  localparam logic [2:0]  PCRC_CYC_WORD      = 3'h4;
  localparam logic [2:0]  PCRC_CYC_HALF      = 3'h2;
  localparam logic [2:0]  PCRC_CYC_BYTE      = 3'h1;

  // access size on the bus
  typedef enum logic [1:0] {
    PCRC_SIZE_BYTE = 2'b00,
    PCRC_SIZE_HALF = 2'b01,
    PCRC_SIZE_WORD = 2'b10
  } pcrc_size_e;

  // polynomial width select
  typedef enum logic [1:0] {
    PCRC_POLY_32 = 2'b00,
    PCRC_POLY_16 = 2'b01,
    PCRC_POLY_8  = 2'b10,
    PCRC_POLY_7  = 2'b11
  } pcrc_poly_e;
endpackage

// >>> core/pcrc_step_if.sv
// carrier between the crc engine and its byte step datapath
`timescale 1ns/1ps
interface pcrc_step_if;
  logic [31:0] crc_in;
  logic [7:0]  data_byte;
  logic [31:0] coeff;
  logic [1:0]  poly_sel;
  logic [31:0] crc_out;
  modport engine (output crc_in, output data_byte, output coeff, output poly_sel,
                  input crc_out);
  modport step   (input crc_in, input data_byte, input coeff, input poly_sel,
                  output crc_out);
endinterface

// >>> core/pcrc_byte_step.sv
// one byte of crc, msb first, for a polynomial of 7, 8, 16 or 32 bits
`timescale 1ns/1ps
module pcrc_byte_step
  import pcrc_pkg::*;
(
  pcrc_step_if.step st
);
  // width of the active polynomial
  function automatic int poly_width(input logic [1:0] sel);
    case (sel)
      PCRC_POLY_16: poly_width = 16;
      PCRC_POLY_8:  poly_width = 8;
      PCRC_POLY_7:  poly_width = 7;
      default:      poly_width = 32;
    endcase
  endfunction

  // bitwise shift of eight data bits through the narrow register
  always_comb
  begin
    int          w;
    logic [31:0] c;
    logic [31:0] mask;
    logic        fb;
    fb   = 1'b0;
    w    = poly_width(st.poly_sel); // R8
    mask = (w == 32) ? 32'hFFFFFFFF : ((32'h00000001 << w) - 32'h00000001);
    c    = st.crc_in & mask; // R11
    for (int i = 7; i >= 0; i--)
    begin
      fb = c[w-1] ^ st.data_byte[i];
      c  = ((c << 1) & mask) ^ (fb ? (st.coeff & mask) : 32'h00000000); // R9
    end
    st.crc_out = c;
  end
endmodule // pcrc_byte_step

// >>> core/pcrc_unit.sv
// programmable crc unit with its register file on a simple word bus
`timescale 1ns/1ps
module pcrc_unit
  import pcrc_pkg::*;
#(
  parameter int unsigned DATA_W    = 32, // data path width
  parameter int unsigned ADDR_W    = 5,  // byte offset width
  parameter int unsigned BUF_WORDS = 1   // words held by the input buffer
)
(
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire logic                bus_sel,
  input  wire logic                bus_write,
  input  wire logic [ADDR_W-1:0]   bus_addr,
  input  wire pcrc_pkg::pcrc_size_e bus_size,
  input  wire logic [DATA_W-1:0]   bus_wdata,
  output logic [DATA_W-1:0]        bus_rdata,
  output logic                     bus_ready,
  output logic                     bus_error
);
  import pcrc_pkg::*;

  // registers
  logic [31:0] crc_data;
  logic [31:0] scratch_value;
  logic [7:0]  crc_control;
  logic [31:0] start_value;
  logic [31:0] generator_coefficients;

  // engine state: current job and one buffered job
  logic [31:0] job_word;
  logic [2:0]  job_left;
  logic        buf_full;
  logic [31:0] buf_word;
  pcrc_size_e  buf_size;
  logic        read_pending;
  logic [4:0]  read_addr;

  // address and access decode
  wire logic hit_data    = bus_addr == PCRC_OFS_DATA;
  wire logic hit_scratch = bus_addr == PCRC_OFS_SCRATCH;
  wire logic hit_control = bus_addr == PCRC_OFS_CONTROL;
  wire logic hit_start   = bus_addr == PCRC_OFS_START;
  wire logic hit_coeff   = bus_addr == PCRC_OFS_COEFF;
  wire logic hit_any     = hit_data | hit_scratch | hit_control | hit_start | hit_coeff;
  wire logic size_ok     = hit_data ? (bus_size != 2'b11) : (bus_size == PCRC_SIZE_WORD); // R3
  wire logic take        = bus_sel & bus_ready & ~read_pending;
  wire logic acc_bad     = take & ~(hit_any & size_ok);
  wire logic acc_ok      = take & hit_any & size_ok;
  wire logic wr_data     = acc_ok & bus_write & hit_data;
  wire logic wr_start    = acc_ok & bus_write & hit_start;
  wire logic wr_control  = acc_ok & bus_write & hit_control;
  wire logic rd_ok       = acc_ok & ~bus_write;

  // engine status
  wire logic busy        = job_left != 3'h0;
  wire logic idle        = ~busy & ~buf_full;
  wire logic start_job   = ~busy & buf_full;
  wire logic reload      = wr_control & bus_wdata[PCRC_BIT_RESET]; // R12
  wire logic [1:0] rev_in = crc_control[PCRC_POS_REVIN+1:PCRC_POS_REVIN];

  // bit reversal of the input word by the selected grain
  function automatic logic [31:0] rev_input(input logic [31:0] d, input logic [1:0] m);
    logic [31:0] r;
    r = d;
    for (int i = 0; i < 32; i++)
    begin
      case (m)
        2'b01:   r[i] = d[(i & ~7) + 7 - (i & 7)];
        2'b10:   r[i] = d[(i & ~15) + 15 - (i & 15)];
        2'b11:   r[i] = d[31 - i];
        default: r[i] = d[i];
      endcase
    end
    return r;
  endfunction

  // number of byte steps for an access size
  function automatic logic [2:0] step_count(input pcrc_size_e s);
    case (s)
      PCRC_SIZE_BYTE: step_count = PCRC_CYC_BYTE;
      PCRC_SIZE_HALF: step_count = PCRC_CYC_HALF;
      default:        step_count = PCRC_CYC_WORD;
    endcase
  endfunction

  // full bit reversal for the read view
  function automatic logic [31:0] rev_full(input logic [31:0] d);
    for (int i = 0; i < 32; i++)
      rev_full[i] = d[31 - i];
  endfunction

  // narrow writes are left aligned so the job always takes the top byte first
  wire logic [31:0] in_rev   = rev_input(bus_wdata, rev_in); // R6
  wire logic [31:0] in_align = (bus_size == PCRC_SIZE_BYTE) ? {in_rev[7:0], 24'h000000} :
                               (bus_size == PCRC_SIZE_HALF) ? {in_rev[15:0], 16'h0000} :
                               in_rev; // R2 R11
  wire logic [2:0]  in_steps = step_count(bus_size); // R4

  // byte step datapath
  pcrc_step_if st ();
  assign st.crc_in    = crc_data;
  assign st.data_byte = job_word[31:24];
  assign st.coeff     = generator_coefficients; // R9
  assign st.poly_sel  = crc_control[PCRC_POS_SIZE+1:PCRC_POS_SIZE]; // R8
  pcrc_byte_step u_step (
    .st (st)
  );

  // read mux, data view optionally reversed
  wire logic [31:0] data_view = crc_control[PCRC_BIT_REVOUT] ? rev_full(crc_data) : crc_data; // R7 R17
  wire logic [4:0]  rd_sel    = read_pending ? read_addr : bus_addr;
  wire logic [31:0] rd_mux    = (rd_sel == PCRC_OFS_DATA)    ? data_view :
                                (rd_sel == PCRC_OFS_SCRATCH) ? scratch_value :
                                (rd_sel == PCRC_OFS_CONTROL) ? {24'h000000, crc_control} :
                                (rd_sel == PCRC_OFS_START)   ? start_value :
                                (rd_sel == PCRC_OFS_COEFF)   ? generator_coefficients :
                                32'h00000000;
  wire logic stall_read = rd_ok & hit_data & ~idle; // R17
  wire logic done_read  = read_pending & idle;

  // software registers
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      scratch_value          <= PCRC_RST_SCRATCH; // R16
      start_value            <= PCRC_RST_START;
      generator_coefficients <= PCRC_RST_COEFF;
      crc_control            <= PCRC_RST_CONTROL;
    end
    else
    begin
      if (acc_ok & bus_write & hit_scratch)
        scratch_value <= bus_wdata; // R14
      if (wr_start)
        start_value <= bus_wdata;
      if (acc_ok & bus_write & hit_coeff)
        generator_coefficients <= bus_wdata; // R9 R15
      if (wr_control)
        crc_control <= {bus_wdata[7:3], 3'b000}; // R12
    end
  end

  // crc register: reload has priority, then step the running job
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
      crc_data <= PCRC_RST_DATA; // R16
    else if (wr_start)
      crc_data <= bus_wdata; // R13
    else if (reload)
      crc_data <= start_value; // R12
    else if (busy)
      crc_data <= st.crc_out; // R1
  end

  // job sequencer with one deep input buffer
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      job_word <= 32'h00000000;
      job_left <= 3'h0;
      buf_full <= 1'b0;
      buf_word <= 32'h00000000;
      buf_size <= PCRC_SIZE_WORD;
    end
    else if (wr_start | reload)
    begin
      job_left <= 3'h0;
      buf_full <= 1'b0;
    end
    else
    begin
      if (busy)
      begin
        job_word <= {job_word[23:0], 8'h00};
        job_left <= job_left - 3'h1; // R4
      end
      else if (buf_full)
      begin
        job_word <= buf_word;
        job_left <= step_count(buf_size);
      end
      if (wr_data)
      begin
        buf_full <= 1'b1; // R5
        buf_word <= in_align;
        buf_size <= bus_size;
      end
      else if (start_job)
        buf_full <= 1'b0;
    end
  end

  // bus answer: one cycle, or held for a data read until the engine is idle
  always_ff @(posedge clk_sys or posedge reset)
  begin
    if (reset)
    begin
      bus_rdata    <= 32'h00000000;
      bus_ready    <= 1'b1;
      bus_error    <= 1'b0;
      read_pending <= 1'b0;
      read_addr    <= 5'h00;
    end
    else
    begin
      bus_error <= acc_bad; // R3
      if (stall_read)
      begin
        read_pending <= 1'b1; // R17
        read_addr    <= bus_addr;
        bus_ready    <= 1'b0;
      end
      else if (done_read)
      begin
        read_pending <= 1'b0;
        bus_ready    <= 1'b1;
        bus_rdata    <= rd_mux;
      end
      else if (rd_ok)
        bus_rdata <= rd_mux; // R1
    end
  end

  // write to data while the buffer is still full would need a wait state;
  // a job drains the buffer within one cycle of idling, so software writes at most
  // one word per bus cycle and a third back-to-back data write overwrites a buffered job not yet started
  // refuse shapes that the fixed datapath cannot serve
  if (DATA_W != 32 || ADDR_W != 5 || BUF_WORDS != 1)
  begin : g_bad_shape
    $error("pcrc_unit: unsupported data width, offset width or buffer depth");
  end
endmodule // pcrc_unit

// >>> verif/pcrc_unit_chk.sv
// assertions on the ports of the programmable crc unit
`timescale 1ns/1ps
module pcrc_unit_chk
  import pcrc_pkg::*;
(
  input wire logic                 clk_sys,
  input wire logic                 reset,
  input wire logic                 bus_sel,
  input wire logic                 bus_write,
  input wire logic [4:0]           bus_addr,
  input wire pcrc_pkg::pcrc_size_e bus_size,
  input wire logic [31:0]          bus_wdata,
  input wire logic [31:0]          bus_rdata,
  input wire logic                 bus_ready,
  input wire logic                 bus_error
);
  import pcrc_pkg::*;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  // helper wires for taken accesses and mapped offsets
  logic taken;
  logic rd_data;
  logic map_ok;
  assign taken   = bus_sel && bus_ready;
  assign rd_data = taken && !bus_write && bus_addr == PCRC_OFS_DATA;
  assign map_ok  = bus_addr inside {PCRC_OFS_DATA, PCRC_OFS_SCRATCH, PCRC_OFS_CONTROL,
                                    PCRC_OFS_START, PCRC_OFS_COEFF};

  // an access taken at this edge
  sequence s_take;
    bus_sel && bus_ready;
  endsequence
  // a read of the control register taken at this edge
  sequence s_ctrl_rd;
    s_take ##0 !bus_write && bus_addr == PCRC_OFS_CONTROL && bus_size == PCRC_SIZE_WORD;
  endsequence

  property p_unmapped;
    s_take ##0 !map_ok |=> bus_error;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped access gave no error");
  property p_size_err;
    s_take ##0 bus_addr != PCRC_OFS_DATA && bus_size != PCRC_SIZE_WORD |=> bus_error;
  endproperty
  a_size_err: assert property (p_size_err)
    else $error("narrow access to word register gave no error");
  property p_data_ok;
    s_take ##0 bus_addr == PCRC_OFS_DATA && bus_size != 2'b11 |=> !bus_error;
  endproperty
  a_data_ok: assert property (p_data_ok)
    else $error("legal data access gave an error");
  property p_err_cause;
    bus_error |-> $past(taken);
  endproperty
  a_err_cause: assert property (p_err_cause)
    else $error("error without a taken access");
  property p_wr_nowait;
    s_take ##0 bus_write |=> bus_ready ##0 $stable(bus_rdata);
  endproperty
  a_wr_nowait: assert property (p_wr_nowait)
    else $error("write inserted a wait or moved read data");
  property p_stall_cause;
    $fell(bus_ready) |-> $past(rd_data);
  endproperty
  a_stall_cause: assert property (p_stall_cause)
    else $error("stall without a data read");
  property p_stall_end;
    $fell(bus_ready) |-> ##[1:12] bus_ready;
  endproperty
  a_stall_end: assert property (p_stall_end)
    else $error("data read stall too long");
  property p_ctrl_rd;
    s_ctrl_rd |=> bus_rdata[31:8] == 24'h0 && bus_rdata[2:0] == 3'h0;
  endproperty
  a_ctrl_rd: assert property (p_ctrl_rd)
    else $error("control read shows set reset or reserved bits");
endmodule // pcrc_unit_chk

bind pcrc_unit pcrc_unit_chk u_chk (.clk_sys, .reset, .bus_sel, .bus_write, .bus_addr,
  .bus_size, .bus_wdata, .bus_rdata, .bus_ready, .bus_error);

// >>> verif/pcrc_unit_tb.sv
// self-checking testbench of the programmable crc unit
`timescale 1ns/1ps
module pcrc_unit_tb;
  import pcrc_pkg::*;
  logic        clk_sys, reset, bus_sel, bus_write, bus_ready, bus_error;
  logic [4:0]  bus_addr;
  pcrc_size_e  bus_size;
  logic [31:0] bus_wdata, bus_rdata, crc, poly, msk, v;
  logic [33:0] note;
  logic [33:0] notes[$];
  int          errors, n_checks, seed, w;

  pcrc_unit u_dut (.clk_sys, .reset, .bus_sel, .bus_write, .bus_addr, .bus_size,
    .bus_wdata, .bus_rdata, .bus_ready, .bus_error);

  // free running clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // compares each answer with the oldest note
  always
  begin
    @(posedge clk_sys);
    if ((bus_sel & bus_ready & !reset) === 1'b1)
    begin
      @(negedge clk_sys);
      note = notes.pop_front();
      chk("error", {31'h0, note[32]}, {31'h0, bus_error});
      while (bus_ready !== 1'b1) @(negedge clk_sys);
      if (note[33]) chk("rdata", note[31:0], bus_rdata);
    end
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("wrong value %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask

  // one bus access, held until taken
  task automatic acc(input logic wen, input logic [4:0] a, input pcrc_size_e s,
                     input logic [31:0] dd, input logic [33:0] nt);
    notes.push_back(nt);
    bus_sel   <= 1'b1;
    bus_write <= wen;
    bus_addr  <= a;
    bus_size  <= s;
    bus_wdata <= dd;
    do @(posedge clk_sys); while (bus_ready !== 1'b1);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] dd);
    acc(1'b1, a, PCRC_SIZE_WORD, dd, 34'h0);
  endtask

  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, PCRC_SIZE_WORD, 32'h0, {2'b10, e});
  endtask

  task automatic idle();
    bus_sel <= 1'b0;
    @(posedge clk_sys);
  endtask

  // reference crc, bit serial msb first
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] dd,
                                       input int nb);
    logic fb;
    for (int i = nb - 1; i >= 0; i--)
    begin
      fb = c[w - 1] ^ dd[i];
      c = (c << 1) & msk;
      if (fb) c = c ^ poly;
    end
    return c;
  endfunction

  function automatic logic [31:0] rev_in(input logic [31:0] d, input logic [1:0] r);
    logic [31:0] b;
    logic [31:0] bb;
    logic [31:0] bh;
    b  = {<<{d}};
    bb = {<<8{b}};
    bh = {<<16{b}};
    case (r)
      2'd0: return d;
      2'd1: return bb;
      2'd2: return bh;
      default: return b;
    endcase
  endfunction

  // data write that also advances the reference
  task automatic dw(input pcrc_size_e s, input logic [31:0] dd, input logic [1:0] r);
    acc(1'b1, PCRC_OFS_DATA, s, dd, 34'h0);
    crc = fold(crc, rev_in(dd, r), s == PCRC_SIZE_BYTE ? 8 : s == PCRC_SIZE_HALF ? 16 : 32);
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk_sys);
    errors++;
    wrap_up();
  end

  // main sequence
  initial
  begin
    seed = 78646;
    reset = 1'b1;
    bus_sel = 1'b0;
    bus_write = 1'b0;
    bus_addr = 5'h00;
    bus_size = PCRC_SIZE_WORD;
    bus_wdata = 32'h0;
    errors = 0;
    n_checks = 0;
    w = 32;
    msk = 32'hFFFFFFFF;
    poly = PCRC_RST_COEFF;
    repeat (12) @(posedge clk_sys);
    reset <= 1'b0;
    rd(PCRC_OFS_DATA, PCRC_RST_DATA);
    rd(PCRC_OFS_SCRATCH, PCRC_RST_SCRATCH);
    rd(PCRC_OFS_CONTROL, 32'h0);
    rd(PCRC_OFS_START, PCRC_RST_START);
    rd(PCRC_OFS_COEFF, PCRC_RST_COEFF);
    $display("test reset values done");
    v = $random(seed);
    wr(PCRC_OFS_SCRATCH, v);
    wr(PCRC_OFS_CONTROL, 32'h1);
    rd(PCRC_OFS_SCRATCH, v);
    rd(PCRC_OFS_DATA, PCRC_RST_START);
    rd(PCRC_OFS_CONTROL, 32'h0);
    acc(1'b0, 5'h0C, PCRC_SIZE_WORD, 32'h0, {2'b01, 32'h0});
    acc(1'b1, PCRC_OFS_CONTROL, PCRC_SIZE_BYTE, 32'h80, {2'b01, 32'h0});
    rd(PCRC_OFS_CONTROL, 32'h0);
    $display("test registers done");
    for (int r = 0; r < 4; r++)
    begin
      v = $random(seed);
      wr(PCRC_OFS_START, v);
      crc = v;
      wr(PCRC_OFS_CONTROL, {24'h0, r[0], r[1:0], 5'h0});
      dw(PCRC_SIZE_WORD, $random(seed), r[1:0]);
      dw(PCRC_SIZE_WORD, $random(seed), r[1:0]);
      rd(PCRC_OFS_DATA, r[0] ? rev_in(crc, 2'd3) : crc);
    end
    wr(PCRC_OFS_CONTROL, 32'h0);
    rd(PCRC_OFS_DATA, crc);
    $display("test reversal done");
    for (int p = 0; p < 4; p++)
    begin
      w = (p == 3) ? 7 : 32 >> p;
      msk = 32'hFFFFFFFF >> (32 - w);
      poly = ($random(seed) & msk) | 32'h1;
      wr(PCRC_OFS_COEFF, poly);
      wr(PCRC_OFS_CONTROL, p << 3);
      crc = $random(seed) & msk;
      wr(PCRC_OFS_START, crc);
      rd(PCRC_OFS_DATA, crc);
      dw(PCRC_SIZE_BYTE, $random(seed), 2'b00);
      dw(PCRC_SIZE_HALF, $random(seed), 2'b00);
      idle();
      repeat (4) @(posedge clk_sys);
      dw(PCRC_SIZE_WORD, $random(seed), 2'b00);
      rd(PCRC_OFS_DATA, crc);
      rd(PCRC_OFS_COEFF, poly);
    end
    $display("test widths done");
    idle();
    repeat (20) @(posedge clk_sys);
    wrap_up();
  end
endmodule // pcrc_unit_tb
